// [rcs_rx_check.sv]
// Receive CRC checking, configuration and receive status with an AHB-Lite register port
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "rcs_regs.svh"

module rcs_rx_check
    import rcs_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Decoder frame interface
    input wire logic rx_enable_in,
    input wire logic rx_sof_in,
    input wire logic rx_eof_in,
    input wire rcs_bit_t rx_bit_in,
    input wire rcs_proto_err_t rx_proto_err_in,
    input wire rcs_mode_t rx_mode_in,
    // Automatic mode detector
    input wire logic md_event_in,
    input wire rcs_proto_t md_proto_in,
    // Events and state
    output logic receive_done_event_out,
    output logic clash_index_valid_out,
    output logic rx_halted_out
);

    rcs_cfg_t cfg;
    logic [31:0] aux_ctl;
    rcs_state_t state;
    logic [11:0] bit_pos;
    logic par_acc;
    logic clash_seen;
    logic [6:0] first_clash_index;
    logic proto_err;
    logic integrity_err;
    logic [2:0] last_bits;
    logic [3:0] frame_count;
    logic [8:0] byte_count;
    logic clash_index_valid;
    logic multi_frame_receive_on;
    logic rev_parity_stop;
    logic crc_ok;
    logic crc_init;
    logic data_bit;
    logic parity_bit;
    logic any_proto_err;
    logic parity_bad;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [7:0] addr_idx;
    logic addr_take;
    logic [31:0] status_word;
    logic [15:0] seed;

    // Custom seed or one of the fixed presets
    // custom seed
    function automatic logic [15:0] seed_of(input logic [2:0] sel, input logic [15:0] custom);
        unique case (sel)
            `RCS_SEL_ZERO: seed_of = `RCS_SEED_ZERO;
            `RCS_SEL_6363: seed_of = `RCS_SEED_6363;
            `RCS_SEL_A671: seed_of = `RCS_SEED_A671;
            `RCS_SEL_FFFF: seed_of = `RCS_SEED_FFFF;
            `RCS_SEL_0012: seed_of = `RCS_SEED_0012;
            `RCS_SEL_E012: seed_of = `RCS_SEED_E012;
            `RCS_SEL_CUSTOM: seed_of = custom;
            default: seed_of = `RCS_SEED_ZERO; // Reserved code gives no preset
        endcase
    endfunction

    // Bit offset within the frame to whole bytes
    function automatic logic [8:0] bytes_of(input logic [11:0] pos);
        logic [11:0] rounded;
        rounded = pos + 12'h007;
        bytes_of = rounded[11:3];
    endfunction

    assign multi_frame_receive_on = aux_ctl[`RCS_AUX_MULTI_BIT];
    assign rev_parity_stop = aux_ctl[`RCS_AUX_REV_PARITY_BIT];
    assign seed = seed_of(cfg.preset_sel, cfg.preset_value);
    assign crc_init = rx_sof_in;
    assign any_proto_err = |rx_proto_err_in;

    // Bits are taken only while a frame is open and no protocol error has stopped it
    // halt on error
    assign data_bit = (state == RCS_ST_RECV) && rx_bit_in.valid && !rx_bit_in.is_parity && !any_proto_err;
    assign parity_bit = (state == RCS_ST_RECV) && rx_bit_in.valid && rx_bit_in.is_parity && !any_proto_err;
    assign parity_bad = parity_bit && cfg.parity_on && ((par_acc ^ cfg.parity_odd) != rx_bit_in.data);

    // CRC runs over data bits only, parity bits are stripped
    // width select
    rcs_crc_unit i_rcs_crc_unit (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .init_in(crc_init),
        .seed_in(seed),
        .width5_in(cfg.crc_width5),
        .invert_in(cfg.crc_residue_invert),
        .bit_valid_in(data_bit),
        .bit_in(rx_bit_in.data),
        .residue_ok_out(crc_ok)
    );

    // Frame receiver sequence
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            state <= RCS_ST_IDLE;
        end else if (rx_sof_in) begin
            state <= RCS_ST_RECV;
        end else begin
            unique case (state)
                RCS_ST_IDLE: state <= RCS_ST_IDLE;
                RCS_ST_RECV: begin
                    if (rx_eof_in) begin
                        state <= RCS_ST_IDLE;
                    end else if (any_proto_err) begin
                        state <= RCS_ST_HALT;
                    end
                end
                RCS_ST_HALT: begin
                    if (rx_eof_in) begin
                        state <= RCS_ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Bit position counts data bits from the configured first-bit offset
    // offset included
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            bit_pos <= 12'h000;
        end else if (rx_sof_in) begin
            bit_pos <= {9'h000, cfg.bit_align};
        end else if (data_bit) begin
            bit_pos <= bit_pos + 12'h001;
        end
    end

    // Running parity of the data bits of the current byte
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            par_acc <= 1'b0;
        end else if (rx_sof_in || parity_bit) begin
            par_acc <= 1'b0;
        end else if (data_bit) begin
            par_acc <= par_acc ^ rx_bit_in.data;
        end
    end

    // First clash of the frame latches its data-bit position
    // first clash
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            clash_seen <= 1'b0;
            first_clash_index <= 7'h00;
            clash_index_valid <= 1'b0;
        end else if (rx_sof_in) begin
            clash_seen <= 1'b0;
            first_clash_index <= 7'h00;
            clash_index_valid <= 1'b0;
        end else if (data_bit && rx_bit_in.clash && !clash_seen) begin
            clash_seen <= 1'b1;
            first_clash_index <= bit_pos[6:0];
            clash_index_valid <= (rx_mode_in != RCS_MODE_OTHER);
        end
    end

    // Protocol error flag; a new frame clears it but an error in that cycle wins if the state is RCS_ST_RECV
    // protocol error
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            proto_err <= 1'b0;
        end else if ((state == RCS_ST_RECV) && any_proto_err) begin
            proto_err <= 1'b1;
        end else if (rx_sof_in) begin
            proto_err <= 1'b0;
        end
    end

    // Integrity flag from parity per byte and CRC at end of frame; reception goes on
    // integrity flag
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            integrity_err <= 1'b0;
        end else if (parity_bad && !rev_parity_stop) begin
            integrity_err <= 1'b1;
        end else if ((state == RCS_ST_RECV) && rx_eof_in && cfg.crc_check_on && !crc_ok) begin
            integrity_err <= 1'b1;
        end else if (rx_sof_in) begin
            integrity_err <= 1'b0;
        end
    end

    // Done event and frame summary at end of frame
    // last bits
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            receive_done_event_out <= 1'b0;
            last_bits <= 3'h0;
            byte_count <= 9'h000;
        end else begin
            receive_done_event_out <= (state != RCS_ST_IDLE) && rx_eof_in && !rx_sof_in;
            if (rx_enable_in) begin
                last_bits <= 3'h0;
                byte_count <= 9'h000;
            end else if ((state != RCS_ST_IDLE) && rx_eof_in) begin
                last_bits <= bit_pos[2:0];
                byte_count <= bytes_of(bit_pos);
            end
        end
    end

    // Frame counter steps with the done event; restarts when the receiver is enabled
    // frame count
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            frame_count <= 4'h0;
        end else if (rx_enable_in) begin
            frame_count <= 4'h0;
        end else if (receive_done_event_out && multi_frame_receive_on) begin
            frame_count <= frame_count + 4'h1;
        end
    end

    // Status outputs
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            clash_index_valid_out <= 1'b0;
            rx_halted_out <= 1'b0;
        end else begin
            clash_index_valid_out <= clash_index_valid;
            rx_halted_out <= (state == RCS_ST_HALT);
        end
    end

    // Status word; reserved top bits read zero
    assign status_word = {6'h00, first_clash_index, clash_seen, proto_err, integrity_err,
                          last_bits, frame_count, byte_count};

    // Address phase decode
    assign addr_take = hsel && hready && htrans[`RCS_HTRANS_ACTIVE_BIT];
    assign addr_idx = haddr[`RCS_ADDR_LSB +: 8];

    // Bus write is applied in its data phase
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            wr_pend <= 1'b0;
            wr_idx <= 8'h00;
        end else begin
            wr_pend <= addr_take && hwrite;
            wr_idx <= addr_idx;
        end
    end

    // Check configuration; the mode detector wins over a bus write in the same cycle
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            cfg <= `RCS_CHECK_CONFIG_RST;
        end else if (md_event_in) begin
            unique case (md_proto_in)
                RCS_PROTO_A: begin
                    cfg.crc_residue_invert <= 1'b0;
                    cfg.preset_sel <= `RCS_SEL_6363;
                    cfg.parity_on <= 1'b1;
                    cfg.parity_odd <= 1'b1;
                end
                RCS_PROTO_B: begin
                    cfg.crc_residue_invert <= 1'b1;
                    cfg.crc_check_on <= 1'b1;
                    cfg.preset_sel <= `RCS_SEL_FFFF;
                end
                RCS_PROTO_CARD212, RCS_PROTO_CARD424: begin
                    cfg.crc_residue_invert <= 1'b0;
                    cfg.crc_check_on <= 1'b1;
                    cfg.preset_sel <= `RCS_SEL_ZERO;
                end
                default: cfg <= cfg; // Unlisted protocols leave the setting alone
            endcase
        end else if (wr_pend && (wr_idx == `RCS_IDX_CHECK_CONFIG)) begin
            cfg <= hwdata & `RCS_CHECK_CONFIG_WMASK;
        end
    end

    // Auxiliary control: multi-frame receive and reversed-parity end criterion
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            aux_ctl <= `RCS_AUX_CONTROL_RST;
        end else if (wr_pend && (wr_idx == `RCS_IDX_AUX_CONTROL)) begin
            aux_ctl <= {30'h0000_0000, hwdata[`RCS_AUX_REV_PARITY_BIT], hwdata[`RCS_AUX_MULTI_BIT]};
        end
    end

    // Read data registered at the address phase; unmapped and status writes are harmless
    // read-only status
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_take && !hwrite) begin
            unique case (addr_idx)
                `RCS_IDX_CHECK_CONFIG: hrdata <= cfg;
                `RCS_IDX_RECEIVE_STATUS: hrdata <= status_word;
                `RCS_IDX_AUX_CONTROL: begin
                    hrdata <= aux_ctl;
                    hrdata[`RCS_AUX_CLASH_VALID_BIT] <= clash_index_valid;
                    hrdata[`RCS_AUX_HALTED_BIT] <= (state == RCS_ST_HALT);
                end
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // Zero wait states, always OKAY; hsize is accepted as a full word
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// [rcs_regs.svh]
// Register offsets, field positions, reset values and fixed codes of the receive check block
`ifndef RCS_REGS_SVH
`define RCS_REGS_SVH

// Register indices; the byte address is four times the index
`define RCS_IDX_CHECK_CONFIG 8'h12
`define RCS_IDX_RECEIVE_STATUS 8'h13
`define RCS_IDX_AUX_CONTROL 8'h20
`define RCS_ADDR_LSB 2

// Reset values
`define RCS_CHECK_CONFIG_RST 32'h0000_0000
`define RCS_AUX_CONTROL_RST 32'h0000_0000

// Writable bits of the check configuration (bits 15:12 read as zero)
`define RCS_CHECK_CONFIG_WMASK 32'hffff_0fff

// Auxiliary control and state word
`define RCS_AUX_MULTI_BIT 0
`define RCS_AUX_REV_PARITY_BIT 1
`define RCS_AUX_CLASH_VALID_BIT 8
`define RCS_AUX_HALTED_BIT 9

// CRC seed selection codes
`define RCS_SEL_ZERO 3'h0
`define RCS_SEL_6363 3'h1
`define RCS_SEL_A671 3'h2
`define RCS_SEL_FFFF 3'h3
`define RCS_SEL_0012 3'h4
`define RCS_SEL_E012 3'h5
`define RCS_SEL_CUSTOM 3'h7

// CRC seed values
`define RCS_SEED_ZERO 16'h0000
`define RCS_SEED_6363 16'h6363
`define RCS_SEED_A671 16'ha671
`define RCS_SEED_FFFF 16'hffff
`define RCS_SEED_0012 16'h0012
`define RCS_SEED_E012 16'he012

// CRC polynomials and residues
`define RCS_POLY16_REFL 16'h8408
`define RCS_POLY5 5'h09
`define RCS_RESIDUE16_INV 16'hf0b8
`define RCS_RESIDUE16 16'h0000
`define RCS_RESIDUE5 5'h00

// AHB-Lite transfer type with a transfer in it (NONSEQ or SEQ)
`define RCS_HTRANS_ACTIVE_BIT 1

`endif

// [rcs_pkg.sv]
// Types shared by the receive check block and its CRC engine
package rcs_pkg;

    // Check configuration word as laid out in the register
    typedef struct packed {
        logic [15:0] preset_value;
        logic [3:0] rfu;
        logic parity_odd;
        logic parity_on;
        logic values_after_clash;
        logic [2:0] bit_align;
        logic [2:0] preset_sel;
        logic crc_width5;
        logic crc_residue_invert;
        logic crc_check_on;
    } rcs_cfg_t;

    // One demodulated bit from the decoder
    typedef struct packed {
        logic valid;
        logic data;
        logic is_parity;
        logic clash;
    } rcs_bit_t;

    // Framing faults flagged by the decoder
    typedef struct packed {
        logic stop_bit;
        logic sof;
        logic eof;
        logic length;
    } rcs_proto_err_t;

    // Protocols reported by the automatic mode detector
    typedef enum logic [2:0] {
        RCS_PROTO_A = 3'h0,
        RCS_PROTO_B = 3'h1,
        RCS_PROTO_CARD212 = 3'h2,
        RCS_PROTO_CARD424 = 3'h3,
        RCS_PROTO_OTHER = 3'h4
    } rcs_proto_t;

    // Link modes; a clash position means something in all but RCS_MODE_OTHER
    typedef enum logic [2:0] {
        RCS_MODE_PASSIVE106 = 3'h0,
        RCS_MODE_14443A = 3'h1,
        RCS_MODE_CRYPTO = 3'h2,
        RCS_MODE_15693 = 3'h3,
        RCS_MODE_OTHER = 3'h4
    } rcs_mode_t;

    // Frame receiver states
    typedef enum logic [2:0] {
        RCS_ST_IDLE = 3'b001,
        RCS_ST_RECV = 3'b010,
        RCS_ST_HALT = 3'b100
    } rcs_state_t;

endpackage

// [rcs_crc_unit.sv]
// Bit-serial CRC engine, 16-bit reflected or 5-bit, with residue check
`timescale 1ns/1ps
`default_nettype none
`include "rcs_regs.svh"

module rcs_crc_unit
    import rcs_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // Control
    input wire logic init_in,
    input wire logic [15:0] seed_in,
    input wire logic width5_in,
    input wire logic invert_in,
    // Data
    input wire logic bit_valid_in,
    input wire logic bit_in,
    // Result
    output logic residue_ok_out
);

    logic [15:0] crc;

    // One shift of the selected polynomial
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b, input logic w5);
        logic fb;
        logic [4:0] c5;
        fb = 1'b0;
        c5 = 5'h00;
        if (w5) begin
            fb = c[4] ^ b;
            c5 = {c[3:0], 1'b0} ^ (fb ? `RCS_POLY5 : 5'h00);
            crc_step = {11'h000, c5};
        end else begin
            fb = c[0] ^ b;
            crc_step = {1'b0, c[15:1]} ^ (fb ? `RCS_POLY16_REFL : 16'h0000);
        end
    endfunction

    // Short CRC takes only the low byte of the seed, trimmed to five bits
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            crc <= 16'h0000;
        end else if (init_in) begin
            crc <= width5_in ? {11'h000, seed_in[4:0]} : seed_in;
        end else if (bit_valid_in) begin
            crc <= crc_step(crc, bit_in, width5_in);
        end
    end

    // Residue after data and checksum bits, plain, or inverted for the 16-bit CRC only
    always_comb begin
        if (width5_in) begin
            residue_ok_out = (crc[4:0] == `RCS_RESIDUE5);
        end else if (invert_in) begin
            residue_ok_out = (crc == `RCS_RESIDUE16_INV);
        end else begin
            residue_ok_out = (crc == `RCS_RESIDUE16);
        end
    end

endmodule
`default_nettype wire

// [rcs_rx_check_props.sv]
// Bus and frame-event checker for the receive check block
`timescale 1ns/1ps
`default_nettype none
`include "rcs_regs.svh"

module rcs_rx_check_props
    import rcs_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // Register bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Frame link
    input wire logic rx_sof_in,
    input wire logic rx_eof_in,
    input wire rcs_proto_err_t rx_proto_err_in,
    input wire logic receive_done_event_out,
    input wire logic rx_halted_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);

    // Read taken in an address phase
    sequence rd_ph;
        hsel && hready && htrans[1] && !hwrite;
    endsequence
    // Read of an index with nothing behind it
    sequence unm_rd;
        rd_ph ##0 !(haddr[9:2] inside {`RCS_IDX_CHECK_CONFIG, `RCS_IDX_RECEIVE_STATUS, `RCS_IDX_AUX_CONTROL});
    endsequence
    // Frame end and its done pulse
    sequence frame_end;
        rx_eof_in ##1 receive_done_event_out;
    endsequence

    bus_ready_a: assert property (hreadyout) else $error("hreadyout low");
    bus_okay_a: assert property (!hresp) else $error("error response");
    rd_hold_a: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
        else $error("read data moved without a read");
    // A silent slot reads zero, so software sees no stale data
    unmapped_zero_a: assert property (unm_rd |=> hrdata == 32'h0) else $error("unmapped read not zero");
    done_cause_a: assert property (receive_done_event_out |-> $past(rx_eof_in))
        else $error("done without frame end");
    done_single_a: assert property (frame_end |=> !receive_done_event_out) else $error("done too long");
    // Halt shows two edges after the faulty bit: state first, then the output register
    halt_cause_a: assert property ($rose(rx_halted_out) |-> $past(rx_proto_err_in, 2) != '0)
        else $error("halt without error");
    halt_hold_a: assert property (rx_halted_out && !$past(rx_sof_in) && !$past(rx_eof_in) |=> rx_halted_out)
        else $error("halt dropped in frame");
    halt_clear_a: assert property (rx_sof_in && rx_proto_err_in == '0 |-> ##2 !rx_halted_out)
        else $error("halt kept past start");
endmodule

bind rcs_rx_check rcs_rx_check_props i_props (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rx_sof_in(rx_sof_in), .rx_eof_in(rx_eof_in),
    .rx_proto_err_in(rx_proto_err_in), .receive_done_event_out(receive_done_event_out),
    .rx_halted_out(rx_halted_out));
`default_nettype wire

// [rcs_card_model.sv]
// Card-side frame source feeding the decoder interface
`timescale 1ns/1ps
`default_nettype none

module rcs_card_model
    import rcs_pkg::*;
(
    input wire logic mclk_in,
    output logic en_out,
    output logic sof_out,
    output logic eof_out,
    output rcs_bit_t bit_out,
    output rcs_proto_err_t err_out
);
    logic v = 0, d = 0, p = 0, c = 0, idle = 0;
    initial {en_out, sof_out, eof_out, err_out} = '0;
    // Idle data toggles so a stale bit never looks settled
    always @(posedge mclk_in) idle <= ~idle;
    assign bit_out = v ? {1'b1, d, p, c} : {1'b0, idle, 2'b00};

    // Odd parity after each byte; perr 1 sends it wrong, -1 sends none
    task automatic fr(input logic en, input logic [63:0] x, input int n, perr, cl, ea, ek);
        en_out <= en;
        @(posedge mclk_in) en_out <= 0;
        sof_out <= 1;
        @(posedge mclk_in) sof_out <= 0;
        for (int i = 0; i < n; i++) begin
            {v, d, p, c} <= {1'b1, x[i], 1'b0, i == cl};
            err_out <= (i == ea) ? rcs_proto_err_t'(4'h1 << ek) : '0;
            @(posedge mclk_in);
            if (perr >= 0 && i % 8 == 7) begin
                {v, d, p, c} <= {1'b1, ~^x[i-:8] ^ perr[0], 2'b10};
                err_out <= '0;
                @(posedge mclk_in);
            end
        end
        {v, eof_out, err_out} <= {1'b0, 1'b1, 4'h0};
        @(posedge mclk_in) eof_out <= 0;
        repeat (3) @(posedge mclk_in);
    endtask
endmodule
`default_nettype wire

// [rcs_rx_check_tb.sv]
// Self-checking bench for the receive check block
`timescale 1ns/1ps
`default_nettype none
`include "rcs_regs.svh"

module rcs_rx_check_tb
    import rcs_pkg::*;
;
    localparam logic [31:0] A_CFG = {22'h0, `RCS_IDX_CHECK_CONFIG, 2'h0};
    localparam logic [31:0] A_ST = {22'h0, `RCS_IDX_RECEIVE_STATUS, 2'h0};
    localparam logic [31:0] A_AUX = {22'h0, `RCS_IDX_AUX_CONTROL, 2'h0};
    logic mclk_in = 0, sys_rst_in = 1, hsel = 0, hwrite = 0, md_event_in = 0;
    logic [31:0] haddr = 0, hwdata = 0;
    logic [1:0] htrans = 0;
    rcs_mode_t rx_mode_in = RCS_MODE_14443A;
    rcs_proto_t md_proto_in = RCS_PROTO_OTHER;
    wire logic [31:0] hrdata;
    wire logic hready, hresp, done, valid, halted, en, sof, eof;
    wire rcs_bit_t bt;
    wire rcs_proto_err_t pe;
    int err_count = 0, compares = 0, cyc = 0;
    logic saw_halt = 0;
    // Remembers a halt inside the current frame; the receiver leaves halt again at frame end
    always @(posedge mclk_in) saw_halt <= sof ? 1'b0 : (saw_halt | halted);

    always #10 mclk_in = ~mclk_in;
    rcs_rx_check i_rcs_rx_check (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .rx_enable_in(en), .rx_sof_in(sof), .rx_eof_in(eof),
        .rx_bit_in(bt), .rx_proto_err_in(pe), .rx_mode_in(rx_mode_in), .md_event_in(md_event_in),
        .md_proto_in(md_proto_in), .receive_done_event_out(done), .clash_index_valid_out(valid),
        .rx_halted_out(halted));
    rcs_card_model i_rcs_card_model (.mclk_in(mclk_in), .en_out(en), .sof_out(sof), .eof_out(eof),
        .bit_out(bt), .err_out(pe));

    // Single AHB-Lite transfer, waiting on hready in both phases
    task automatic bus(input logic [31:0] a, d, input logic w, output logic [31:0] q);
        {hsel, haddr, hwrite, htrans} <= {1'b1, a, w, 2'h2};
        do @(posedge mclk_in); while (hready !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        do @(posedge mclk_in); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, d);
        logic [31:0] q;
        bus(a, d, 1, q);
    endtask
    task automatic rc(input logic [31:0] a, m, e);
        logic [31:0] q;
        bus(a, 0, 0, q);
        compares++;
        if ((q & m) !== e) begin
            err_count++;
            $display("MISMATCH t=%0t addr %h got %h want %h", $time, a, q & m, e);
        end
    endtask
    task automatic ck(input logic g, e);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH t=%0t flag %b want %b", $time, g, e);
        end
    endtask
    function automatic logic [15:0] c16(logic [15:0] s, logic [15:0] x);
        for (int i = 0; i < 16; i++) s = (s >> 1) ^ ((s[0] ^ x[i]) ? 16'h8408 : 16'h0);
        return s;
    endfunction
    function automatic logic [4:0] c5(logic [4:0] s, logic [10:0] x);
        for (int i = 0; i < 11; i++) s = {s[3:0], 1'b0} ^ ((s[4] ^ x[i]) ? 5'h09 : 5'h0);
        return s;
    endfunction

    task automatic t_regs;
        logic [31:0] ad [4] = '{A_CFG, A_ST, A_AUX, 32'h44};
        foreach (ad[i]) rc(ad[i], 32'hffffffff, 0);
        wr(A_CFG, 32'hffffffff);
        rc(A_CFG, 32'hffffffff, 32'hffff0fff);
        wr(A_ST, 32'hffffffff);
        rc(A_ST, 32'hffffffff, 0);
    endtask
    task automatic t_crc;
        rcs_cfg_t c;
        logic [15:0] s;
        logic [15:0] sd [8] = '{16'h0, 16'h6363, 16'ha671, 16'hffff, 16'h0012, 16'he012, 16'h0, 16'h1234};
        c = '0;
        c.preset_value = 16'h1234;
        c.preset_sel = 3'h7;
        for (int k = 0; k < 2; k++) begin
            c.crc_check_on = (k == 0);
            wr(A_CFG, c);
            i_rcs_card_model.fr(1, {c16(16'h1234, 16'h5a5a) ^ 16'h1, 16'h5a5a}, 32, -1, -1, -1, 0);
            rc(A_ST, 32'h10000, (k == 0) ? 32'h10000 : 0);
        end
        c.crc_check_on = 1;
        for (int k = 0; k < 8; k++) begin
            c.preset_sel = 3'(k);
            c.crc_residue_invert = k[0];
            s = c16(sd[k], 16'h5a5a) ^ {16{k[0]}};
            wr(A_CFG, c);
            i_rcs_card_model.fr(1, {s, 16'h5a5a}, 32, -1, -1, -1, 0);
            rc(A_ST, 32'h1e1ff, 32'h4);
        end
        {c.crc_width5, c.preset_sel, c.crc_residue_invert} = 5'b10010;
        wr(A_CFG, c);
        s[4:0] = c5(5'h03, 11'h5a5);
        i_rcs_card_model.fr(1, {s[0], s[1], s[2], s[3], s[4], 11'h5a5}, 16, -1, -1, -1, 0);
        rc(A_ST, 32'h1e1ff, 32'h2);
    endtask
    task automatic t_proto;
        wr(A_CFG, 0);
        for (int k = 0; k < 4; k++) begin
            i_rcs_card_model.fr(1, 16'ha5a5, 16, -1, -1, 5, k);
            rc(A_ST, 32'h3ffff, 32'h2a001);
            ck(saw_halt, 1);
        end
        i_rcs_card_model.fr(1, 16'ha5a5, 16, -1, -1, -1, 0);
        rc(A_ST, 32'h3ffff, 32'h2);
        ck(saw_halt, 0);
    endtask
    task automatic t_clash;
        wr(A_CFG, 32'h0c0);
        for (int k = 0; k < 2; k++) begin
            rx_mode_in <= k ? RCS_MODE_OTHER : RCS_MODE_14443A;
            i_rcs_card_model.fr(1, 16'h0fff, 12, -1, 5, -1, 0);
            rc(A_ST, 32'h3ffffff, 32'h44e002);
            ck(valid, k == 0);
        end
    endtask
    task automatic t_par;
        wr(A_CFG, 32'hc00);
        for (int k = 0; k < 3; k++) begin
            wr(A_AUX, (k == 2) ? 32'h2 : 32'h0);
            i_rcs_card_model.fr(1, 16'h3c5a, 16, k > 0, -1, -1, 0);
            rc(A_ST, 32'h101ff, (k == 1) ? 32'h10002 : 32'h2);
        end
        wr(A_AUX, 0);
    endtask
    // frame count and clear on enable
    task automatic t_multi;
        wr(A_AUX, 1);
        for (int k = 0; k < 4; k++) begin
            i_rcs_card_model.fr(k != 1 && k != 2, 16'h00ff, 16, -1, -1, -1, 0);
            rc(A_ST, 32'h1fff, ((k == 3) ? 32'h1 : 32'(k + 1)) << 9 | 32'h2);
        end
        wr(A_AUX, 0);
    endtask
    // mode detector sets or clears check bits
    task automatic t_mdet;
        rcs_proto_t pr [4] = '{RCS_PROTO_A, RCS_PROTO_B, RCS_PROTO_CARD212, RCS_PROTO_CARD424};
        logic [31:0] ex [4] = '{32'h0, 32'h3, 32'h1, 32'h1};
        for (int k = 0; k < 4; k++) begin
            wr(A_CFG, (k == 1) ? 32'h0 : 32'h2);
            md_proto_in <= pr[k];
            md_event_in <= 1'b1;
            @(posedge mclk_in) md_event_in <= 0;
            @(posedge mclk_in);
            rc(A_CFG, 32'h3, ex[k]);
        end
    endtask

    // Closing verdict, reached from the sequence or the timeout
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Cycle ceiling well above the expected run length
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            $display("MISMATCH t=%0t timeout", $time);
            final_report;
        end
    end
    // Main sequence
    initial begin
        repeat (12) @(posedge mclk_in);
        sys_rst_in <= 0;
        @(posedge mclk_in);
        t_regs;
        t_crc;
        t_proto;
        t_clash;
        t_par;
        t_multi;
        t_mdet;
        final_report;
    end
endmodule
`default_nettype wire
